// ---- design/rslp_pkg.sv ----
// Behaviour
// (R1) Sector lock B2h stores access rights and sets the sector lock forever.
// (R2) Sector number is a 16-bit block address; 32 blocks form one sector.
// (R3) One lock command locks every block of the selected sector.
// (R4) Lock and fast read with protocol-extension flag at 0 get an error reply.
// (R5) Reader sends no modulation during the write or compare cycle.
// (R6) Lock request: flags, code, maker code, optional id, sector, status, CRC.
// (R7) Status byte: bits 7-5 zero, 4-3 password, 2-1 protection, bit 0 locked.
// (R8) Lock errors: 10h no block, 11h already locked, 14h programming failed.
// (R9) Busy mode drives the pin low from start of frame to end of reply.
// (R10) Write-progress mode drives the pin low for a lock only while programming.
// (R11) Write-progress mode leaves the pin released for password and fast read.
// (R12) Password B3h compares the 32-bit value with the selected stored secret.
// (R13) Password number 01h..03h selects a secret; anything else returns 10h.
// (R14) Correct password changes access to every block linked to it.
// (R15) Password reply follows the compare cycle; mismatch returns 0Fh.
// (R16) Fast read C0h returns the 32-bit content of the 16-bit block number.
// (R17) Fast read reply goes out at twice the normal data rate.
// (R18) Fast read with subcarrier flag not 0 gets an error reply.
// (R19) Option flag puts the sector status byte before the block data.
// (R20) Fast read errors: 10h no block, 15h read protected.
// (R21) Error reply: flags with error bit, error code, CRC.
// (R22) Requests with a bad CRC are dropped without reply or state change.
// (R23) Lock state survives field loss; password unlock ends at field loss.
package rslp_pkg;

	// ****************************************************************
	// command codes and request fields
	// ****************************************************************
	localparam logic [7:0]  CMD_LOCK      = 8'hB2;
	localparam logic [7:0]  CMD_PRESENT   = 8'hB3;
	localparam logic [7:0]  CMD_FAST_READ = 8'hC0;
	localparam logic [7:0]  MAKER_CODE    = 8'h5A; // arbitrary value
	localparam int unsigned FLG_SUBCARRIER = 0;
	localparam int unsigned FLG_PEXT       = 3;
	localparam int unsigned FLG_OPTION     = 6;
	localparam logic [7:0]  PW_NUM_MIN    = 8'h01;
	localparam logic [7:0]  PW_NUM_MAX    = 8'h03;

	// ****************************************************************
	// response flags and error codes
	// ****************************************************************
	localparam logic [7:0]  RSP_FLAGS_OK  = 8'h00;
	localparam logic [7:0]  RSP_FLAGS_ERR = 8'h01;
	localparam logic [7:0]  ERR_OPTION    = 8'h03;
	localparam logic [7:0]  ERR_NO_BLOCK  = 8'h10;
	localparam logic [7:0]  ERR_LOCKED    = 8'h11;
	localparam logic [7:0]  ERR_LOCK_FAIL = 8'h14;
	localparam logic [7:0]  ERR_PW_BAD    = 8'h0F;
	localparam logic [7:0]  ERR_READ_PROT = 8'h15;

	// ****************************************************************
	// sector layout and status byte fields
	// ****************************************************************
	localparam int unsigned SECTOR_SHIFT  = 5;
	localparam int unsigned SST_LOCK_BIT  = 0;
	localparam int unsigned SST_RW_LSB    = 1;
	localparam int unsigned SST_PW_LSB    = 3;
	localparam logic [1:0]  RW_READ_GUARD = 2'h2;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS          = 4;
	localparam int unsigned NOMINAL_REPLY_DELAY_NS = 320_900;
	localparam int unsigned PROG_STEPS             = 18;
	localparam int unsigned PROG_STEP_US           = 302;
	localparam int unsigned PROGRAM_CYCLE_TIME_NS  = NOMINAL_REPLY_DELAY_NS + PROG_STEPS * PROG_STEP_US * 1000;
	localparam int unsigned PROG_CYCLES = (PROGRAM_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [11:0] REG_CTRL       = 12'h000;
	localparam logic [11:0] REG_STATUS     = 12'h004;
	localparam logic [11:0] REG_SECRET_ONE = 12'h008;
	localparam logic [11:0] REG_SECRET_TWO = 12'h00C;
	localparam logic [11:0] REG_SECRET_THR = 12'h010;
	localparam logic [11:0] REG_MEM_ADDR   = 12'h014;
	localparam logic [11:0] REG_MEM_DATA   = 12'h018;
	localparam int unsigned CTRL_MODE_BIT  = 0;
	localparam logic [31:0] SECRET_RESET   = 32'h0000_0000;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_FRAME = 3'b001,
		ST_CHECK = 3'b010,
		ST_PROG  = 3'b011,
		ST_RESP  = 3'b100,
		ST_TX    = 3'b101
	} rslp_state_t;

endpackage

// ---- design/rslp_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module rslp_mem #(
	parameter int unsigned W  = 8,
	parameter int unsigned AW = 6
) (
	// clock
	input  wire logic          pclk,
	// write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	// read port
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data_q
);

	// blank contents at power-up, kept across resets
	logic [W-1:0] mem [0:(1<<AW)-1] = '{default: '0};

	// write port
	always_ff @(posedge pclk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// registered read port
	always_ff @(posedge pclk)
	begin
		if (rd_en)
			rd_data_q <= mem[rd_addr];
	end

endmodule
`default_nettype wire

// ---- design/rslp_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module rslp_timer #(
	parameter int unsigned CYCLES = 1
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// control
	input  wire logic start,
	output logic      busy_q,
	output logic      done_q
);

	logic [31:0] count_q;

	// down counter, done pulses CYCLES edges after start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_q <= 32'h0000_0000;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (start)
			begin
				count_q <= 32'(CYCLES - 1);
				busy_q  <= 1'b1;
			end
			else if (busy_q)
			begin
				if (count_q == 32'h0000_0000)
				begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
				else
					count_q <= count_q - 32'h0000_0001;
			end
		end
	end

endmodule
`default_nettype wire

// ---- design/rslp_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module rslp_core #(
	parameter int unsigned NUM_BLOCKS  = 2048,
	parameter int unsigned PROG_CYCLES = rslp_pkg::PROG_CYCLES
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// decoded request from the framing engine
	input  wire logic        req_sof,
	input  wire logic        req_valid,
	input  wire logic        req_crc_ok,
	input  wire logic [7:0]  req_flags,
	input  wire logic [7:0]  req_cmd,
	input  wire logic [7:0]  req_maker,
	input  wire logic [15:0] req_addr,
	input  wire logic [7:0]  req_byte,
	input  wire logic [31:0] req_word,
	// field and programming status
	input  wire logic        field_off,
	input  wire logic        prog_fail,
	// response to the framing engine
	output logic             rsp_valid,
	output logic      [7:0]  rsp_flags,
	output logic             rsp_err_present,
	output logic      [7:0]  rsp_err_code,
	output logic             rsp_status_present,
	output logic      [7:0]  rsp_status,
	output logic             rsp_data_present,
	output logic      [31:0] rsp_data,
	output logic             rsp_fast,
	input  wire logic        rsp_start,
	input  wire logic        rsp_done,
	// activity pin, open drain
	output logic             rf_activity_pin_o,
	output logic             rf_activity_pin_oe_n
);

	localparam int unsigned BLK_AW = $clog2(NUM_BLOCKS);
	localparam int unsigned SEC_AW = BLK_AW - rslp_pkg::SECTOR_SHIFT;
	localparam logic [16:0] NB     = 17'(NUM_BLOCKS);

	rslp_pkg::rslp_state_t state_q, state_d;
	logic [7:0]  cmd_q, flags_q, byte_q;
	logic [15:0] addr_q;
	logic [31:0] word_q;
	logic        mode_wip_q;
	logic [31:0] secret_q [0:2];
	logic [BLK_AW-1:0] mem_addr_q;
	logic [2:0]  unlock_q;
	logic [7:0]  last_err_q;
	logic [7:0]  sec_rd, sec_wdata;
	logic [31:0] blk_rd;
	logic        sec_wr, blk_wr, rd_go, tmr_start, tmr_busy, tmr_done;
	logic        wr_acc, blk_oob, pw_ok, pw_match;
	logic [1:0]  pw_idx;

	// ****************************************************************
	// decoding helpers
	// ****************************************************************
	// read blocked when locked, guarded and its password not shown
	function automatic logic read_blocked(input logic [7:0] st, input logic [2:0] unl);
		logic [1:0] sel;
		sel = st[rslp_pkg::SST_PW_LSB +: 2];
		read_blocked = st[rslp_pkg::SST_LOCK_BIT]
			&& (st[rslp_pkg::SST_RW_LSB +: 2] >= rslp_pkg::RW_READ_GUARD)
			&& ((sel == 2'h0) || !unl[sel - 2'h1]); // see (R14)
	endfunction

	function automatic logic pw_num_ok(input logic [7:0] num);
		pw_num_ok = (num >= rslp_pkg::PW_NUM_MIN) && (num <= rslp_pkg::PW_NUM_MAX);
	endfunction

	// ****************************************************************
	// storage: block data and nonvolatile sector table
	// ****************************************************************
	rslp_mem #(.W(32), .AW(BLK_AW)) u_blocks (
		.pclk      (pclk),
		.wr_en     (blk_wr),
		.wr_addr   (mem_addr_q),
		.wr_data   (pwdata),
		.rd_en     (rd_go),
		.rd_addr   (req_addr[BLK_AW-1:0]),
		.rd_data_q (blk_rd)
	);

	// one entry per sector, never cleared by reset (see (R23))
	rslp_mem #(.W(8), .AW(SEC_AW)) u_sectors (
		.pclk      (pclk),
		.wr_en     (sec_wr),
		.wr_addr   (addr_q[BLK_AW-1:rslp_pkg::SECTOR_SHIFT]),
		.wr_data   (sec_wdata),
		.rd_en     (rd_go),
		.rd_addr   (req_addr[BLK_AW-1:rslp_pkg::SECTOR_SHIFT]), // see (R2)
		.rd_data_q (sec_rd)
	);

	rslp_timer #(.CYCLES(PROG_CYCLES)) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (tmr_start),
		.busy_q  (tmr_busy),
		.done_q  (tmr_done)
	);

	// ****************************************************************
	// apb slave, one wait-free access phase
	// ****************************************************************
	assign wr_acc = psel && penable && pwrite && pready && !pslverr;
	assign blk_wr = wr_acc && (paddr == rslp_pkg::REG_MEM_DATA);

	// answer prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable)
			begin
				case (paddr)
					rslp_pkg::REG_CTRL:
						prdata <= {31'h0000_0000, mode_wip_q};
					rslp_pkg::REG_STATUS:
						prdata <= {15'h0000, tmr_busy, last_err_q, 1'b0, unlock_q, 1'b0, state_q};
					rslp_pkg::REG_MEM_ADDR:
						prdata <= 32'(mem_addr_q);
					rslp_pkg::REG_SECRET_ONE, rslp_pkg::REG_SECRET_TWO,
					rslp_pkg::REG_SECRET_THR, rslp_pkg::REG_MEM_DATA:
						prdata <= 32'h0000_0000;
					default:
						pslverr <= 1'b1;
				endcase
			end
		end
	end

	// control, secrets and loader address, data write advances address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_wip_q  <= 1'b0;
			secret_q[0] <= rslp_pkg::SECRET_RESET;
			secret_q[1] <= rslp_pkg::SECRET_RESET;
			secret_q[2] <= rslp_pkg::SECRET_RESET;
			mem_addr_q  <= '0;
		end
		else if (wr_acc)
		begin
			case (paddr)
				rslp_pkg::REG_CTRL:       mode_wip_q  <= pwdata[rslp_pkg::CTRL_MODE_BIT];
				rslp_pkg::REG_SECRET_ONE: secret_q[0] <= pwdata;
				rslp_pkg::REG_SECRET_TWO: secret_q[1] <= pwdata;
				rslp_pkg::REG_SECRET_THR: secret_q[2] <= pwdata;
				rslp_pkg::REG_MEM_ADDR:   mem_addr_q  <= pwdata[BLK_AW-1:0];
				rslp_pkg::REG_MEM_DATA:   mem_addr_q  <= mem_addr_q + 1'b1;
				default:                  mode_wip_q  <= mode_wip_q;
			endcase
		end
	end

	// ****************************************************************
	// command sequencer
	// ****************************************************************
	assign rd_go = (state_q == rslp_pkg::ST_FRAME) && req_valid;
	assign blk_oob = {1'b0, addr_q} >= NB;
	assign pw_ok = pw_num_ok(byte_q);
	assign pw_idx = byte_q[1:0] - 2'h1;
	assign pw_match = (word_q == secret_q[pw_idx]); // see (R12)
	assign tmr_start = (state_q == rslp_pkg::ST_CHECK) && (state_d == rslp_pkg::ST_PROG);
	assign sec_wr = (state_q == rslp_pkg::ST_PROG) && tmr_done && (cmd_q == rslp_pkg::CMD_LOCK) && !prog_fail;
	// upper bits forced to zero, lock bit set (see (R7))
	assign sec_wdata = {3'h0, byte_q[4:1], 1'b1};

	// next state
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			rslp_pkg::ST_IDLE:
				if (req_sof)
					state_d = rslp_pkg::ST_FRAME;
			rslp_pkg::ST_FRAME:
				if (req_valid)
				begin
					// bad crc or foreign frame: silent drop (see (R22))
					if (req_crc_ok && (req_maker == rslp_pkg::MAKER_CODE)
						&& ((req_cmd == rslp_pkg::CMD_LOCK) || (req_cmd == rslp_pkg::CMD_PRESENT)
						|| (req_cmd == rslp_pkg::CMD_FAST_READ)))
						state_d = rslp_pkg::ST_CHECK;
					else
						state_d = rslp_pkg::ST_IDLE;
				end
			rslp_pkg::ST_CHECK:
				if ((cmd_q == rslp_pkg::CMD_LOCK) && flags_q[rslp_pkg::FLG_PEXT] && !blk_oob
					&& !sec_rd[rslp_pkg::SST_LOCK_BIT])
					state_d = rslp_pkg::ST_PROG;
				else if ((cmd_q == rslp_pkg::CMD_PRESENT) && pw_ok)
					state_d = rslp_pkg::ST_PROG;
				else
					state_d = rslp_pkg::ST_RESP;
			rslp_pkg::ST_PROG:
				if (tmr_done)
					state_d = rslp_pkg::ST_RESP; // see (R15)
			rslp_pkg::ST_RESP:
				if (rsp_start)
					state_d = rslp_pkg::ST_TX;
			rslp_pkg::ST_TX:
				if (rsp_done)
					state_d = rslp_pkg::ST_IDLE;
			default:
				state_d = rslp_pkg::ST_IDLE;
		endcase
		if (field_off)
			state_d = rslp_pkg::ST_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= rslp_pkg::ST_IDLE;
		else
			state_q <= state_d;
	end

	// request fields captured with the frame (see (R6))
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_q   <= 8'h00;
			flags_q <= 8'h00;
			addr_q  <= 16'h0000;
			byte_q  <= 8'h00;
			word_q  <= 32'h0000_0000;
		end
		else if (rd_go)
		begin
			cmd_q   <= req_cmd;
			flags_q <= req_flags;
			addr_q  <= req_addr;
			byte_q  <= req_byte;
			word_q  <= req_word;
		end
	end

	// password unlock, lost when the field drops (see (R23))
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			unlock_q <= 3'h0;
		else if (field_off)
			unlock_q <= 3'h0;
		else if ((state_q == rslp_pkg::ST_PROG) && tmr_done && (cmd_q == rslp_pkg::CMD_PRESENT) && pw_match)
			unlock_q[pw_idx] <= 1'b1; // see (R14)
	end

	// ****************************************************************
	// response builder
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rsp_valid          <= 1'b0;
			rsp_flags          <= rslp_pkg::RSP_FLAGS_OK;
			rsp_err_present    <= 1'b0;
			rsp_err_code       <= 8'h00;
			rsp_status_present <= 1'b0;
			rsp_status         <= 8'h00;
			rsp_data_present   <= 1'b0;
			rsp_data           <= 32'h0000_0000;
			rsp_fast           <= 1'b0;
			last_err_q         <= 8'h00;
		end
		else
		begin
			rsp_valid <= (state_d == rslp_pkg::ST_RESP);
			if (state_q == rslp_pkg::ST_CHECK)
			begin
				rsp_fast           <= (cmd_q == rslp_pkg::CMD_FAST_READ); // see (R17)
				rsp_err_present    <= 1'b0;
				rsp_flags          <= rslp_pkg::RSP_FLAGS_OK;
				rsp_status_present <= 1'b0;
				rsp_data_present   <= 1'b0;
				rsp_status         <= sec_rd;
				rsp_data           <= blk_rd; // see (R16)
				if ((cmd_q != rslp_pkg::CMD_PRESENT) && !flags_q[rslp_pkg::FLG_PEXT])
				begin
					rsp_err_present <= 1'b1; // see (R4)
					rsp_flags       <= rslp_pkg::RSP_FLAGS_ERR;
					rsp_err_code    <= rslp_pkg::ERR_OPTION;
				end
				else if ((cmd_q == rslp_pkg::CMD_FAST_READ) && flags_q[rslp_pkg::FLG_SUBCARRIER])
				begin
					rsp_err_present <= 1'b1; // see (R18)
					rsp_flags       <= rslp_pkg::RSP_FLAGS_ERR;
					rsp_err_code    <= rslp_pkg::ERR_OPTION;
				end
				else if ((cmd_q == rslp_pkg::CMD_PRESENT) && !pw_ok)
				begin
					rsp_err_present <= 1'b1; // see (R13)
					rsp_flags       <= rslp_pkg::RSP_FLAGS_ERR;
					rsp_err_code    <= rslp_pkg::ERR_NO_BLOCK;
				end
				else if ((cmd_q != rslp_pkg::CMD_PRESENT) && blk_oob)
				begin
					rsp_err_present <= 1'b1; // see (R8) see (R20)
					rsp_flags       <= rslp_pkg::RSP_FLAGS_ERR;
					rsp_err_code    <= rslp_pkg::ERR_NO_BLOCK;
				end
				else if ((cmd_q == rslp_pkg::CMD_LOCK) && sec_rd[rslp_pkg::SST_LOCK_BIT])
				begin
					rsp_err_present <= 1'b1; // see (R1) see (R8)
					rsp_flags       <= rslp_pkg::RSP_FLAGS_ERR;
					rsp_err_code    <= rslp_pkg::ERR_LOCKED;
				end
				else if ((cmd_q == rslp_pkg::CMD_FAST_READ) && read_blocked(sec_rd, unlock_q))
				begin
					rsp_err_present <= 1'b1; // see (R20)
					rsp_flags       <= rslp_pkg::RSP_FLAGS_ERR;
					rsp_err_code    <= rslp_pkg::ERR_READ_PROT;
				end
				else if (cmd_q == rslp_pkg::CMD_FAST_READ)
				begin
					rsp_status_present <= flags_q[rslp_pkg::FLG_OPTION]; // see (R19)
					rsp_data_present   <= 1'b1;
				end
			end
			else if ((state_q == rslp_pkg::ST_PROG) && tmr_done)
			begin
				if ((cmd_q == rslp_pkg::CMD_LOCK) && prog_fail)
				begin
					rsp_err_present <= 1'b1; // see (R8)
					rsp_flags       <= rslp_pkg::RSP_FLAGS_ERR;
					rsp_err_code    <= rslp_pkg::ERR_LOCK_FAIL;
				end
				else if ((cmd_q == rslp_pkg::CMD_PRESENT) && !pw_match)
				begin
					rsp_err_present <= 1'b1; // see (R15)
					rsp_flags       <= rslp_pkg::RSP_FLAGS_ERR;
					rsp_err_code    <= rslp_pkg::ERR_PW_BAD;
				end
			end
			if ((state_q == rslp_pkg::ST_RESP) && rsp_start && rsp_err_present)
				last_err_q <= rsp_err_code;
		end
	end

	// ****************************************************************
	// activity pin: open drain, pulled low while active
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rf_activity_pin_o    <= 1'b0;
			rf_activity_pin_oe_n <= 1'b1;
		end
		else
		begin
			rf_activity_pin_o <= 1'b0;
			if (!mode_wip_q)
				rf_activity_pin_oe_n <= (state_d == rslp_pkg::ST_IDLE); // see (R9)
			else
				rf_activity_pin_oe_n <= !((state_d == rslp_pkg::ST_PROG) && (cmd_q == rslp_pkg::CMD_LOCK)); // see (R10) see (R11)
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_check_cmd(logic [7:0] c);
		(state_q == rslp_pkg::ST_CHECK) && (cmd_q == c);
	endsequence

	a_lock_once_only: assert property (sec_wr |-> (cmd_q == rslp_pkg::CMD_LOCK) && !prog_fail
		&& $past(tmr_busy)) else $error("sector written outside a lock program cycle"); // see (R1)
	a_sector_select: assert property (rd_go |=> (addr_q[BLK_AW-1:rslp_pkg::SECTOR_SHIFT]
		== $past(req_addr[BLK_AW-1:rslp_pkg::SECTOR_SHIFT]))) else $error("sector index wrong"); // see (R2) see (R3)
	a_pext_refused: assert property (s_check_cmd(rslp_pkg::CMD_FAST_READ) ##0 !flags_q[rslp_pkg::FLG_PEXT]
		|=> rsp_valid && rsp_err_present && (rsp_err_code == rslp_pkg::ERR_OPTION)) else $error("no ext error"); // see (R4)
	a_relock_refused: assert property (s_check_cmd(rslp_pkg::CMD_LOCK) ##0 flags_q[rslp_pkg::FLG_PEXT]
		&& !blk_oob && sec_rd[0] |=> (rsp_err_code == rslp_pkg::ERR_LOCKED)
		&& (state_q == rslp_pkg::ST_RESP)) else $error("relock not refused"); // see (R8)
	a_prog_holds: assert property ((state_q == rslp_pkg::ST_PROG) && !tmr_done && !field_off
		|=> (state_q == rslp_pkg::ST_PROG) && !rsp_valid) else $error("reply before program cycle end"); // see (R15)
	a_busy_pin_low: assert property (!mode_wip_q && $past(!mode_wip_q) && (state_q != rslp_pkg::ST_IDLE)
		|-> !rf_activity_pin_oe_n) else $error("busy pin not driven"); // see (R9)
	a_wip_released: assert property (mode_wip_q && $past(mode_wip_q) && (cmd_q != rslp_pkg::CMD_LOCK)
		&& $stable(cmd_q) |-> rf_activity_pin_oe_n) else $error("pin driven in write mode"); // see (R11)
	a_fast_rate: assert property (rsp_valid && (cmd_q == rslp_pkg::CMD_FAST_READ)
		|-> rsp_fast) else $error("fast reply not at double rate"); // see (R17)
	a_bad_crc_drop: assert property ((state_q == rslp_pkg::ST_FRAME) && req_valid && !req_crc_ok
		|=> (state_q == rslp_pkg::ST_IDLE) [*2]) else $error("bad crc frame not dropped"); // see (R22)
	a_err_flags: assert property (rsp_valid && rsp_err_present
		|-> (rsp_flags == rslp_pkg::RSP_FLAGS_ERR)) else $error("error reply without error flag"); // see (R21)

endmodule
`default_nettype wire

// ---- dv/rslp_reader.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// reader side model
// ****
module rslp_reader (
	// clock
	input  wire logic        pclk,
	// request fields
	output logic             req_sof,
	output logic             req_valid,
	output logic             req_crc_ok,
	output logic      [7:0]  req_flags,
	output logic      [7:0]  req_cmd,
	output logic      [7:0]  req_maker,
	output logic      [15:0] req_addr,
	output logic      [7:0]  req_byte,
	output logic      [31:0] req_word,
	// reply handshake
	input  wire logic        rsp_valid,
	output logic             rsp_start,
	output logic             rsp_done
);
	// quiet lines at start
	initial
	begin
		{req_sof, req_valid, req_crc_ok, rsp_start, rsp_done} = 5'h0;
		{req_flags, req_cmd, req_maker, req_addr, req_byte, req_word} = '1;
	end
	// one exchange; no new frame until the reply is out
	task automatic xfer(input logic [79:0] v, input logic ok, input int slow, output logic got);
		int n;
		begin
			req_sof <= 1'b1;
			@(posedge pclk);
			req_sof <= 1'b0;
			req_valid <= 1'b1;
			req_crc_ok <= ok;
			{req_flags, req_cmd, req_maker, req_addr, req_byte, req_word} <= v;
			@(posedge pclk);
			req_valid <= 1'b0;
			req_crc_ok <= ~ok;
			{req_flags, req_cmd, req_maker, req_addr, req_byte, req_word} <= ~v;
			n = 0;
			do @(posedge pclk); while (!rsp_valid && ++n < 60);
			got = rsp_valid;
			if (got)
			begin
				repeat (slow) @(posedge pclk);
				rsp_start <= 1'b1;
				@(posedge pclk);
				rsp_start <= 1'b0;
				repeat (slow + 2) @(posedge pclk);
				rsp_done <= 1'b1;
				@(posedge pclk);
				rsp_done <= 1'b0;
			end
			@(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        field_off = 1'b0, prog_fail = 1'b0, pready, pslverr, req_sof, req_valid, req_crc_ok;
	logic        rsp_valid, rsp_err_present, rsp_status_present, rsp_data_present, rsp_fast, rsp_start;
	logic        rsp_done, rf_activity_pin_o, rf_activity_pin_oe_n, mode, got;
	logic [7:0]  req_flags, req_cmd, req_maker, req_byte, rsp_flags, rsp_err_code, rsp_status, st [64];
	logic [11:0] paddr = 12'h000;
	logic [15:0] req_addr;
	logic [31:0] pwdata = 32'h0000_0000, prdata, req_word, rsp_data, mem [2048], sec [4];
	logic [3:0]  un;
	int          failures = 0, samples_checked = 0, seed = 96975, lowcnt = 0, blk [4] = '{0, 32, 63, 2047};
	// ****
	// design and reader
	// ****
	rslp_core #(.NUM_BLOCKS(2048), .PROG_CYCLES(20)) dut_u (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .req_sof, .req_valid, .req_crc_ok, .req_flags,
		.req_cmd, .req_maker, .req_addr, .req_byte, .req_word, .field_off, .prog_fail, .rsp_valid,
		.rsp_flags, .rsp_err_present, .rsp_err_code, .rsp_status_present, .rsp_status,
		.rsp_data_present, .rsp_data, .rsp_fast, .rsp_start, .rsp_done, .rf_activity_pin_o,
		.rf_activity_pin_oe_n);
	rslp_reader rd_u (.pclk, .req_sof, .req_valid, .req_crc_ok, .req_flags, .req_cmd, .req_maker,
		.req_addr, .req_byte, .req_word, .rsp_valid, .rsp_start, .rsp_done);
	// clock and pin-low cycle count
	always #2 pclk = ~pclk;
	always @(posedge pclk)
		lowcnt <= lowcnt + int'(!rf_activity_pin_oe_n);
	// ****
	// tasks
	// ****
	task automatic conclude;
		begin
			$display("checks %0d mismatches %0d", samples_checked, failures);
			if (failures == 0 && samples_checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task automatic cmp(input logic [63:0] g, x);
		begin
			samples_checked++;
			if (g !== x)
			begin
				failures++;
				$display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
			end
		end
	endtask
	// apb cycle, compares pready, pslverr and read data
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
		int n;
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			do @(posedge pclk); while (!pready && ++n < 20);
			cmp({pready, pslverr, prdata}, {1'b1, x});
			if (!pready)
				conclude;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	// one request against the reference model
	task automatic run(input logic [7:0] f, c, input logic [15:0] a, input logic [7:0] b,
		input logic [31:0] w, input logic ok = 1'b1, pf = 1'b0);
		int e, k, base;
		logic [7:0] s;
		begin
			e = 0;
			k = a >> 5;
			s = st[k];
			if (c != 8'hB3 && !f[3]) e = 'h03;
			else if (c == 8'hC0 && f[0]) e = 'h03;
			else if (c == 8'hB3 && (b < 1 || b > 3)) e = 'h10;
			else if (c != 8'hB3 && a >= 2048) e = 'h10;
			else if (c == 8'hB2 && s[0]) e = 'h11;
			else if (c == 8'hB2 && pf) e = 'h14;
			else if (c == 8'hC0 && s[0] && s[2:1] >= 2 && !un[s[4:3]]) e = 'h15;
			else if (c == 8'hB3 && w !== sec[b]) e = 'h0F;
			if (ok && !e && c == 8'hB2) st[k] = {3'h0, b[4:1], 1'b1};
			if (ok && !e && c == 8'hB3) un[b] = 1'b1;
			prog_fail <= pf;
			base = lowcnt;
			rd_u.xfer({f, c, rslp_pkg::MAKER_CODE, a, b, w}, ok, $random(seed) & 3, got);
			cmp(got, ok);
			if (got !== ok)
				conclude;
			if (ok)
			begin
				cmp({rsp_flags, rsp_err_present, rsp_data_present, rsp_fast},
					{e ? 8'h01 : 8'h00, e != 0, !e && c == 8'hC0, c == 8'hC0});
				if (e)
					cmp(rsp_err_code, e[7:0]);
				else if (c == 8'hC0)
					cmp({rsp_status_present, f[6] ? rsp_status : 8'h00, rsp_data},
						{f[6], f[6] ? s : 8'h00, mem[a]});
			end
			base = lowcnt - base;
			cmp(mode ? (c == 8'hB2 ? e == 0 && (base < 19 || base > 23) : base != 0) : base == 0, 0);
			cmp({rf_activity_pin_oe_n, rf_activity_pin_o}, 2'b10);
			$display("done %h %h", f, c);
		end
	endtask
	// ****
	// main sequence
	// ****
	initial
	begin
		foreach (st[i]) st[i] = 8'h00;
		un = 4'h0;
		mode = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 12'h000, 0, 0);
		apb(0, 12'hFFC, 0, 33'h1_0000_0000);
		for (int i = 1; i < 4; i++)
		begin
			sec[i] = $random(seed);
			apb(1, 12'h004 + 4 * i, sec[i], 0);
			apb(0, 12'h004 + 4 * i, 0, 0);
		end
		foreach (blk[j])
		begin
			mem[blk[j]] = $random(seed);
			apb(1, 12'h014, blk[j], j ? blk[j-1] + 1 : 0);
			apb(1, 12'h018, mem[blk[j]], 0);
		end
		run(8'h08, 8'hC0, 0, 0, 0);
		run(8'h48, 8'hC0, 2047, 0, 0);
		run(8'h00, 8'hC0, 0, 0, 0);
		run(8'h09, 8'hC0, 0, 0, 0);
		run(8'h08, 8'hC0, 2048, 0, 0);
		run(8'h08, 8'hB2, 40, 8'h0D, 0, 1'b0);
		rd_u.xfer({16'h08C0, ~rslp_pkg::MAKER_CODE, 56'h0}, 1'b1, 0, got);
		cmp(got, 1'b0);
		run(8'h08, 8'hB2, 40, 8'hED, 0);
		run(8'h08, 8'hB2, 33, 8'h0D, 0);
		run(8'h00, 8'hB2, 70, 8'h0D, 0);
		run(8'h08, 8'hB2, 4096, 8'h0D, 0);
		run(8'h08, 8'hB2, 70, 8'h0D, 0, 1'b1, 1'b1);
		run(8'h48, 8'hC0, 63, 0, 0);
		run(8'h48, 8'hC0, 0, 0, 0);
		run(8'h08, 8'hB3, 0, 8'h00, 0);
		run(8'h08, 8'hB3, 0, 8'h04, 0);
		run(8'h08, 8'hB3, 0, 8'h01, ~sec[1]);
		run(8'h08, 8'hB3, 0, 8'h01, sec[1]);
		run(8'h48, 8'hC0, 32, 0, 0);
		field_off <= 1'b1;
		@(posedge pclk);
		field_off <= 1'b0;
		un = 4'h0;
		@(posedge pclk);
		run(8'h48, 8'hC0, 63, 0, 0);
		mode = 1'b1;
		apb(1, 12'h000, 1, 0);
		run(8'h08, 8'hB2, 2047, 8'h01, 0);
		run(8'h08, 8'hC0, 2047, 0, 0);
		run(8'h08, 8'hB3, 0, 8'h02, sec[2]);
		conclude;
	end
endmodule
`default_nettype wire
